// ===== sim/pmcc_sta_model.sv
// Station management model: makes the management clock and frames.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module pmcc_sta_model
   import pmcc_pkg::*;
(
   // Core clock and resolved data line.
   input wire logic clk_in,
   input wire logic line_in,
   // Management clock and data drive.
   output logic mdc_out,
   output logic drv_out,
   output logic oe_out
);
   initial begin
      mdc_out = 1'b0;
      drv_out = 1'b1;
      oe_out = 1'b0;
   end
   // One bit: launch while the clock is low, sample at its rise.
   task automatic bit_cyc(input logic b, input logic en, output logic s);
      mdc_out <= 1'b0;
      drv_out <= b;
      oe_out <= en;
      repeat (6) @(posedge clk_in);
      mdc_out <= 1'b1;
      s = line_in;
      repeat (6) @(posedge clk_in);
   endtask
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
         input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [63:0] f;
      logic s;
      f = {32'hffffffff, MDIO_START, op, pa, ra, 2'h2, wd};
      rd = 16'h0;
      for (int i = 63; i >= 0; i--) begin
         bit_cyc(f[i], op == MDIO_OP_WRITE || i > 17, s);
         if (i < 16) begin
            rd[i] = s;
         end
      end
      // The clock stands still low between frames.
      mdc_out <= 1'b0;
      oe_out <= 1'b0;
      repeat (12) @(posedge clk_in);
   endtask
endmodule

// ===== sim/pmcc_top_sva.sv
// Assertion checker for the carrier, collision and management pins.
// Assumes it is bound to pmcc_top and sees only its ports.
`timescale 1ns/1ps
module pmcc_top_sva
   import pmcc_pkg::*;
(
   // Clock, reset and register writes.
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [4:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   // Line, controller and management pins.
   input wire logic line_rx_raw_in,
   input wire logic tx_en_in,
   input wire logic col_out,
   input wire logic crs_out,
   input wire logic duplex_select_in,
   input wire logic node_repeater_select_in,
   input wire logic mdc_in,
   input wire logic mdio_out,
   input wire logic mdio_oe_out
);
   logic [15:0] cfg_q;
   logic [2:0] age_q;
   logic ok;
   logic tenm;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   // Mirror of the configuration written over the register port.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cfg_q <= CFG_RESET | {12'h0, node_repeater_select_in, 3'h0};
         age_q <= 3'h0;
      end else if (reg_wr_in && reg_addr_in == REG_CFG) begin
         cfg_q <= reg_wdata_in;
         age_q <= 3'h0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end
   assign ok = age_q >= 3'h4;
   assign tenm = ok && !cfg_q[CFG_SPEED_100_BIT];
   a_col_fdx_low: assert property (duplex_select_in [*4] |=> !col_out)
      else $error("collision high in full duplex");
   a_col_on_overlap: assert property (
      (tenm && !duplex_select_in && tx_en_in && line_rx_raw_in) [*4]
      |=> col_out) else $error("collision missing on overlap");
   a_col_drop_out: assert property (
      ((!tx_en_in || (tenm && !line_rx_raw_in)) && ok
      && cfg_q[CFG_SELFTEST_SUPPRESS_BIT]) [*4] |=> !col_out)
      else $error("collision without overlap");
   a_crs_node_tx: assert property (
      (ok && !duplex_select_in && !cfg_q[CFG_REPEATER_BIT] && tx_en_in) [*4]
      |=> crs_out) else $error("carrier missing on transmit");
   a_crs_rx_only: assert property (
      (tenm && (duplex_select_in || cfg_q[CFG_REPEATER_BIT]) && tx_en_in
      && !line_rx_raw_in) [*4] |=> !crs_out)
      else $error("carrier from own transmit");
   a_selftest_pulse: assert property (
      $fell(tx_en_in) && tenm && !duplex_select_in && !line_rx_raw_in
      && cfg_q[3:2] == 2'h0 |-> ##[15:25] col_out)
      else $error("self-test pulse missing");
   a_ta_drive_zero: assert property ($rose(mdio_oe_out) |-> !mdio_out)
      else $error("turnaround bit not zero");
   a_mdio_clk_step: assert property (
      $changed(mdio_out) || $changed(mdio_oe_out) |-> !$past(mdc_in, 2))
      else $error("data line moved off the clock low phase");
endmodule
bind pmcc_top pmcc_top_sva u_sva (.core_clk_in, .sys_rst_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .line_rx_raw_in, .tx_en_in, .col_out,
   .crs_out, .duplex_select_in, .node_repeater_select_in, .mdc_in,
   .mdio_out, .mdio_oe_out);

// ===== sim/pmcc_top_tb.sv
// Self-checking bench for the carrier, collision and management block.
// Assumes the station model and the bound checker are compiled with it.
`timescale 1ns/1ps
module pmcc_top_tb;
   import pmcc_pkg::*;
   logic clk, rst, wr, rd, raw, rxc, rxb, tx, fdx, strap;
   logic mdc, sdrv, soe, line, col, crs, mdo, mdoe, clash;
   logic [4:0] addr;
   logic [15:0] wd, rdat;
   logic [31:0] seed;
   int fail_count, comparisons;
   // Shared data line with its pull-up.
   assign line = mdoe ? mdo : (soe ? sdrv : 1'b1);
   pmcc_top dut (.core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdat), .line_rx_raw_in(raw), .line_rx_clk_in(rxc),
      .line_rx_bit_in(rxb), .tx_en_in(tx), .col_out(col), .crs_out(crs),
      .duplex_select_in(fdx), .node_repeater_select_in(strap),
      .mdc_in(mdc), .mdio_in(line), .mdio_out(mdo), .mdio_oe_out(mdoe));
   pmcc_sta_model sta (.clk_in(clk), .line_in(line), .mdc_out(mdc),
      .drv_out(sdrv), .oe_out(soe));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (mdoe && soe) begin
         clash <= 1'b1;
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic col_exp(input logic t, r, f);
      return t & r & !f;
   endfunction
   function automatic logic crs_exp(input logic t, r, f, p);
      return r | (t & !f & !p);
   endfunction
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic do_reset(input logic s);
      rst <= 1'b1;
      strap <= s;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdat;
   endtask
   task automatic settle(input logic t, input logic r, input logic f);
      tx <= t;
      raw <= r;
      fdx <= f;
      repeat (6) @(posedge clk);
   endtask
   task automatic send(input logic [9:0] p, input int n);
      for (int j = n - 1; j >= 0; j--) begin
         rxb <= p[j];
         rxc <= 1'b0;
         repeat (4) @(posedge clk);
         rxc <= 1'b1;
         repeat (4) @(posedge clk);
      end
      rxc <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done();
   end
   initial begin
      logic [15:0] r;
      int n, first;
      {rst, wr, rd, raw, rxc, tx, fdx, strap, clash} = 9'h0;
      {rxb, addr, wd} = 22'h200000;
      seed = 32'h55677cc5;
      fail_count = 0;
      comparisons = 0;
      do_reset(1'b0);
      rd_reg(REG_CFG, r);
      chk(r, CFG_RESET);
      rd_reg(5'h1f, r);
      chk(r, 16'h0);
      wr_reg(REG_STAT, 16'hffff);
      rd_reg(REG_STAT, r);
      chk(r, 16'h0);
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         wr_reg(REG_CFG, {12'h0, seed[3], 3'h4});
         settle(seed[0], seed[1], seed[2]);
         chk(16'(col), 16'(col_exp(seed[0], seed[1], seed[2])));
         chk(16'(crs), 16'(crs_exp(seed[0], seed[1], seed[2], seed[3])));
      end
      for (int i = 0; i < 2; i++) begin
         wr_reg(REG_CFG, i ? 16'h0004 : 16'h0000);
         settle(1'b1, 1'b0, 1'b0);
         tx <= 1'b0;
         n = 0;
         first = 0;
         for (int k = 1; k <= 50; k++) begin
            @(posedge clk);
            if (col === 1'b1) begin
               first = n == 0 ? k : first;
               n++;
            end
         end
         chk(16'(n), i ? 16'h0 : 16'(SQE_WIDTH_CYC));
         chk(16'(i || first > SQE_DELAY_CYC && first < SQE_DELAY_CYC + 6),
            16'h1);
      end
      wr_reg(REG_CFG, 16'h0005);
      settle(1'b1, 1'b1, 1'b0);
      send(10'h0ff, 10);
      chk(16'(col), 16'h0);
      send(10'h002, 3);
      chk(16'(col), 16'h1);
      send(10'h3ff, 10);
      chk(16'(col), 16'h0);
      do_reset(1'b1);
      rd_reg(REG_CFG, r);
      chk(r, CFG_RESET | 16'h0008);
      settle(1'b1, 1'b0, 1'b0);
      chk(16'(crs), 16'h0);
      settle(1'b0, 1'b0, 1'b0);
      sta.frame(MDIO_OP_WRITE, MDIO_PHY_ADDR_DEF, REG_CFG, 16'h000c, r);
      sta.frame(MDIO_OP_WRITE, 5'h02, REG_CFG, 16'h0001, r);
      sta.frame(MDIO_OP_READ, MDIO_PHY_ADDR_DEF, REG_CFG, 16'h0, r);
      chk(r, 16'h000c);
      rd_reg(REG_CFG, r);
      chk(r, 16'h000c);
      chk(16'(clash), 16'h0);
      test_done();
   end
endmodule

// ===== src/pmcc_mdio_slave.sv
// Serial management slave: frames on the sampled management clock.
// Assumes clock and data inputs arrive already synchronised.
`timescale 1ns/1ps
module pmcc_mdio_slave
   import pmcc_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = MDIO_PHY_ADDR_DEF
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Synchronised management pins.
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_out,
   // Register access.
   pmcc_mgmt_if.master mgmt
);

   pmcc_md_type state_q;
   logic mdc_q;
   logic rise;
   logic fall;
   logic [5:0] pre_q;
   logic [4:0] cnt_q;
   logic [13:0] hdr_q;
   logic [15:0] sh_q;
   logic rd_q;
   logic wr_q;

   assign rise = mdc_in && !mdc_q;
   assign fall = !mdc_in && mdc_q;
   assign mgmt.addr = hdr_q[4:0];
   assign mgmt.wdata = sh_q;
   assign mgmt.wr = wr_q;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= mdc_in;
      end
   end

   // Every bit is taken on a rising management clock edge.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_q <= MD_PRE;
         pre_q <= '0;
         cnt_q <= '0;
         hdr_q <= '0;
         sh_q <= '0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         if (rise) begin
            unique case (state_q)
               MD_PRE: begin
                  if (mdio_in) begin
                     if (pre_q != 6'h3f) begin
                        pre_q <= pre_q + 6'h01;
                     end
                  end else begin
                     if (pre_q >= 6'(MDIO_PRE_MIN)) begin
                        state_q <= MD_HDR;
                        cnt_q <= 5'h01;
                        hdr_q <= '0;
                     end
                     pre_q <= '0;
                  end
               end
               MD_HDR: begin
                  hdr_q <= {hdr_q[12:0], mdio_in};
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'(MDIO_HDR_BITS - 1)) begin
                     cnt_q <= '0;
                     // Held bits: second start bit, operation, device address.
                     if (hdr_q[11] == MDIO_START[0] &&
                         hdr_q[8:4] == PHY_ADDR &&
                         (hdr_q[10:9] == MDIO_OP_READ ||
                          hdr_q[10:9] == MDIO_OP_WRITE)) begin
                        state_q <= MD_TA;
                        rd_q <= (hdr_q[10:9] == MDIO_OP_READ);
                     end else begin
                        state_q <= MD_PRE;
                     end
                  end
               end
               MD_TA: begin
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'h01) begin
                     cnt_q <= '0;
                     state_q <= MD_DATA;
                     sh_q <= mgmt.rdata;
                  end
               end
               MD_DATA: begin
                  sh_q <= {sh_q[14:0], mdio_in};
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'h0f) begin
                     state_q <= MD_PRE;
                     wr_q <= !rd_q;
                     rd_q <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // The line is driven only for a read's second turnaround bit and its data, changed on falling edges.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         mdio_oe_out <= 1'b0;
         mdio_out <= 1'b0;
      end else if (fall) begin
         mdio_oe_out <= rd_q && ((state_q == MD_TA && cnt_q == 5'h01) ||
                                 state_q == MD_DATA);
         mdio_out <= (state_q == MD_DATA) ? sh_q[15] : 1'b0;
      end
   end

endmodule

// ===== src/pmcc_mgmt_if.sv
// Register access path from the serial management slave to the registers.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface pmcc_mgmt_if;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic [15:0] rdata;
   modport master (output addr, output wdata, output wr, input rdata);
   modport slave (input addr, input wdata, input wr, output rdata);
endinterface

// ===== src/pmcc_pkg.sv
// Shared constants of the carrier, collision and management block.
// Assumes a 20 MHz core clock; all times are converted from it.
package pmcc_pkg;

   // Clock and self-test timing.
   localparam int CLK_PERIOD_NS = 50;
   localparam int SQE_DELAY_NS = 800;
   localparam int SQE_WIDTH_NS = 1000;
   localparam int SQE_DELAY_CYC =
      (SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SQE_WIDTH_CYC =
      (SQE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SQE_CNT_W = 8;

   // Register map, addressed by register index.
   localparam int REG_ADDR_W = 5;
   localparam int REG_DATA_W = 16;
   localparam logic [4:0] REG_CFG = 5'h12;
   localparam logic [4:0] REG_STAT = 5'h13;

   // Configuration register fields.
   localparam int CFG_SPEED_100_BIT = 0;
   localparam int CFG_SELFTEST_SUPPRESS_BIT = 2;
   localparam int CFG_REPEATER_BIT = 3;
   localparam logic [15:0] CFG_RESET = 16'h0001;

   // Status register fields.
   localparam int STAT_RX_ACT_BIT = 0;
   localparam int STAT_TX_ACT_BIT = 1;
   localparam int STAT_COL_BIT = 2;
   localparam int STAT_CRS_BIT = 3;
   localparam int STAT_FULL_DUPLEX_BIT = 4;
   localparam int STAT_REPEATER_BIT = 5;

   // Serial management frame.
   localparam int MDIO_PRE_MIN = 32;
   localparam int MDIO_HDR_BITS = 14;
   localparam logic [1:0] MDIO_START = 2'h1;
   localparam logic [1:0] MDIO_OP_READ = 2'h2;
   localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
   localparam logic [4:0] MDIO_PHY_ADDR_DEF = 5'h01;

   // Symbol window for fast-mode activity detection.
   localparam int SYM_BITS = 10;

   typedef enum logic [1:0] {SQE_IDLE, SQE_WAIT, SQE_PULSE} pmcc_sqe_type;
   typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} pmcc_md_type;

endpackage

// ===== src/pmcc_symbol_detect.sv
// Fast-mode receive activity from a 10-bit window of the line bit stream.
// Assumes the bit and its strobe are already synchronised to the core clock.
`timescale 1ns/1ps
module pmcc_symbol_detect
   import pmcc_pkg::*;
#(
   parameter int WIN = SYM_BITS
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Sampled line stream.
   input wire logic bit_in,
   input wire logic strobe_in,
   // Activity.
   output logic active_out
);

   initial begin
      if (WIN < 3) begin
         $error("pmcc_symbol_detect: window too short");
      end
   end

   logic [WIN-1:0] win_q;
   logic hit;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         win_q <= '1;
      end else if (strobe_in) begin
         win_q <= {win_q[WIN-2:0], bit_in};
      end
   end

   // Two zeros at least two positions apart anywhere in the window.
   always_comb begin
      hit = 1'b0;
      for (int i = 0; i < WIN - 2; i++) begin
         for (int j = i + 2; j < WIN; j++) begin
            if (!win_q[i] && !win_q[j]) begin
               hit = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         active_out <= 1'b0;
      end else begin
         active_out <= hit;
      end
   end

endmodule

// ===== src/pmcc_top.sv
// Collision, carrier sense and management pins of the transceiver.
// Assumes all line, controller and management pins are asynchronous.
`timescale 1ns/1ps

module pmcc_top
   import pmcc_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = MDIO_PHY_ADDR_DEF
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Register port.
   input wire logic [4:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   // Line receive side.
   input wire logic line_rx_raw_in,
   input wire logic line_rx_clk_in,
   input wire logic line_rx_bit_in,
   // Controller side.
   input wire logic tx_en_in,
   output logic col_out,
   output logic crs_out,
   // Straps.
   input wire logic duplex_select_in,
   input wire logic node_repeater_select_in,
   // Management pins.
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_out
);

   localparam int NSYNC = 8;
   localparam int S_RAW = 0;
   localparam int S_RXCLK = 1;
   localparam int S_RXBIT = 2;
   localparam int S_TXEN = 3;
   localparam int S_DPX = 4;
   localparam int S_REP = 5;
   localparam int S_MDC = 6;
   localparam int S_MDIO = 7;

   // Elaboration checks on the shared constants this logic relies on.
   initial begin
      if (SQE_DELAY_CYC + SQE_WIDTH_CYC >= (1 << SQE_CNT_W)) begin
         $error("pmcc_top: self-test timing exceeds counter");
      end
      if (SQE_DELAY_CYC < 1 || SQE_WIDTH_CYC < 1) begin
         $error("pmcc_top: self-test delay and width must be non-zero");
      end
      if (SYM_BITS < 3) begin
         $error("pmcc_top: symbol window too short");
      end
      if (MDIO_PRE_MIN < 1 || MDIO_PRE_MIN > 63) begin
         $error("pmcc_top: preamble length outside counter range");
      end
      if (MDIO_HDR_BITS != 14) begin
         $error("pmcc_top: management header length is fixed");
      end
      if (REG_ADDR_W != 5 || REG_DATA_W != 16) begin
         $error("pmcc_top: register port widths are fixed");
      end
      if (REG_CFG == REG_STAT) begin
         $error("pmcc_top: register indices collide");
      end
      if (CFG_SPEED_100_BIT >= REG_DATA_W ||
          CFG_SELFTEST_SUPPRESS_BIT >= REG_DATA_W ||
          CFG_REPEATER_BIT >= REG_DATA_W) begin
         $error("pmcc_top: configuration field outside word");
      end
      if (STAT_RX_ACT_BIT >= REG_DATA_W ||
          STAT_TX_ACT_BIT >= REG_DATA_W ||
          STAT_COL_BIT >= REG_DATA_W ||
          STAT_CRS_BIT >= REG_DATA_W ||
          STAT_FULL_DUPLEX_BIT >= REG_DATA_W ||
          STAT_REPEATER_BIT >= REG_DATA_W) begin
         $error("pmcc_top: status field outside word");
      end
   end

   pmcc_mgmt_if mgmt ();

   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   logic rxclk_prev_q;
   logic rx_strobe;
   logic sym_active;
   logic [15:0] cfg_q;
   logic strap_done_q;
   logic tx_prev_q;
   pmcc_sqe_type sqe_q;
   logic [SQE_CNT_W-1:0] sqe_cnt_q;
   logic speed_100;
   logic repeater;
   logic full_duplex;
   logic rx_act;
   logic tx_act;
   logic sqe_on;
   logic col_d;
   logic crs_d;
   logic [15:0] stat;

   assign async_in = {mdio_in, mdc_in, node_repeater_select_in,
                      duplex_select_in, tx_en_in, line_rx_bit_in,
                      line_rx_clk_in, line_rx_raw_in};

   // Two-stage synchronisers for every pin input.
   // The repeater strap stage keeps sampling in reset, so it is settled at release.
   generate
      for (genvar g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge core_clk_in) begin
            if (sys_rst_in && g != S_REP) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= async_in[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   // Rising edges of the recovered line clock strobe the line bit.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rxclk_prev_q <= 1'b0;
      end else begin
         rxclk_prev_q <= sync_q[S_RXCLK];
      end
   end

   assign rx_strobe = sync_q[S_RXCLK] && !rxclk_prev_q;

   pmcc_symbol_detect #(
      .WIN(SYM_BITS)
   ) u_sym (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .bit_in(sync_q[S_RXBIT]),
      .strobe_in(rx_strobe),
      .active_out(sym_active)
   );

   pmcc_mdio_slave #(
      .PHY_ADDR(PHY_ADDR)
   ) u_mdio (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .mdc_in(sync_q[S_MDC]),
      .mdio_in(sync_q[S_MDIO]),
      .mdio_out(mdio_out),
      .mdio_oe_out(mdio_oe_out),
      .mgmt(mgmt.master)
   );

   // Configuration register; the repeater bit takes the strap once.
   // A register port write wins over a management write in one cycle.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cfg_q <= CFG_RESET;
         strap_done_q <= 1'b0;
      end else begin
         if (!strap_done_q) begin
            cfg_q[CFG_REPEATER_BIT] <= sync_q[S_REP];
            strap_done_q <= 1'b1;
         end
         if (reg_wr_in && reg_addr_in == REG_CFG) begin
            cfg_q <= reg_wdata_in;
         end else if (mgmt.wr && mgmt.addr == REG_CFG) begin
            cfg_q <= mgmt.wdata;
         end
      end
   end

   // Slow mode takes activity before squelch, so collisions are seen early.
   assign speed_100 = cfg_q[CFG_SPEED_100_BIT];
   assign repeater = cfg_q[CFG_REPEATER_BIT];
   assign full_duplex = sync_q[S_DPX];
   assign tx_act = sync_q[S_TXEN];
   assign rx_act = speed_100 ? sym_active : sync_q[S_RAW];

   // Delayed transmit enable marks the end of a frame.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         tx_prev_q <= 1'b0;
      end else begin
         tx_prev_q <= tx_act;
      end
   end

   // Self-test pulse after the end of a 10 Mb/s half-duplex node transmit.
   // Repeaters and full-duplex links give no pulse, so no false collision.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         sqe_q <= SQE_IDLE;
         sqe_cnt_q <= '0;
      end else begin
         unique case (sqe_q)
            SQE_IDLE: begin
               if (tx_prev_q && !tx_act && !speed_100 && !repeater &&
                   !full_duplex && !cfg_q[CFG_SELFTEST_SUPPRESS_BIT]) begin
                  sqe_q <= SQE_WAIT;
                  sqe_cnt_q <= SQE_CNT_W'(SQE_DELAY_CYC - 1);
               end
            end
            SQE_WAIT: begin
               if (sqe_cnt_q == '0) begin
                  sqe_q <= SQE_PULSE;
                  sqe_cnt_q <= SQE_CNT_W'(SQE_WIDTH_CYC - 1);
               end else begin
                  sqe_cnt_q <= sqe_cnt_q - SQE_CNT_W'(1);
               end
            end
            SQE_PULSE: begin
               if (sqe_cnt_q == '0) begin
                  sqe_q <= SQE_IDLE;
               end else begin
                  sqe_cnt_q <= sqe_cnt_q - SQE_CNT_W'(1);
               end
            end
         endcase
      end
   end

   assign sqe_on = (sqe_q == SQE_PULSE) && !full_duplex;

   // Collision during overlap or the self-test pulse, never in full duplex.
   assign col_d = !full_duplex && ((rx_act && tx_act) || sqe_on);

   // Carrier sense per duplex and node/repeater mode.
   assign crs_d = (full_duplex || repeater) ? rx_act : (rx_act || tx_act);

   // Outputs are flops of the core clock, not of any data clock.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         col_out <= 1'b0;
      end else begin
         col_out <= col_d;
      end
   end

   // The controller must synchronise carrier sense as well.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         crs_out <= 1'b0;
      end else begin
         crs_out <= crs_d;
      end
   end

   always_comb begin
      stat = '0;
      stat[STAT_RX_ACT_BIT] = rx_act;
      stat[STAT_TX_ACT_BIT] = tx_act;
      stat[STAT_COL_BIT] = col_out;
      stat[STAT_CRS_BIT] = crs_out;
      stat[STAT_FULL_DUPLEX_BIT] = full_duplex;
      stat[STAT_REPEATER_BIT] = repeater;
   end

   // Management reads see the same map as the register port.
   always_comb begin
      unique case (mgmt.addr)
         REG_CFG: mgmt.rdata = cfg_q;
         REG_STAT: mgmt.rdata = stat;
         default: mgmt.rdata = '0;
      endcase
   end

   // Register port read data stand one cycle after the strobe.
   // Zero outside that cycle keeps a stale word from looking fresh.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            REG_CFG: reg_rdata_out <= cfg_q;
            REG_STAT: reg_rdata_out <= stat;
            default: reg_rdata_out <= '0;
         endcase
      end else begin
         reg_rdata_out <= '0;
      end
   end

endmodule
